// [signal_monitor.sv]
// Register access over AXI4-Lite was decided locally.
module signal_monitor (
    input  wire logic                                sys_clk,
    input  wire logic                                resetn,
    input  wire logic [monitor_pkg::ADDR_W-1:0]      awaddr,
    input  wire logic                                awvalid,
    output logic                                     awready,
    input  wire logic [31:0]                         wdata,
    input  wire logic [3:0]                          wstrb,
    input  wire logic                                wvalid,
    output logic                                     wready,
    output logic [1:0]                               bresp,
    output logic                                     bvalid,
    input  wire logic                                bready,
    input  wire logic [monitor_pkg::ADDR_W-1:0]      araddr,
    input  wire logic                                arvalid,
    output logic                                     arready,
    output logic [31:0]                              rdata,
    output logic [1:0]                               rresp,
    output logic                                     rvalid,
    input  wire logic                                rready,
    input  wire logic [monitor_pkg::SAMPLE_W-1:0]    sample_mag,
    input  wire logic                                sysref_edge,
    output logic [monitor_pkg::RESULT_W-1:0]         link_stat_data,
    output logic                                     link_stat_valid
);
    logic [monitor_pkg::ADDR_W-1:0]   awaddr_q;
    logic                             aw_have_q;
    logic [7:0]                       wdata_q;
    logic                             wlane_q;
    logic                             w_have_q;
    logic                             wr_do;
    logic [9:0]                       wr_idx;
    logic [9:0]                       rd_idx;
    logic [7:0]                       rd_byte;
    logic                             rd_hit;
    logic                             sync_en_q;
    logic                             sync_next_q;
    logic                             peak_en_q;
    logic [23:0]                      period_q;
    logic                             update_q;
    logic [2:0]                       sel_q;
    logic [monitor_pkg::RESULT_W-1:0] result_q;
    logic [7:0]                       tally_rb_q;
    logic [1:0]                       insert_en_q;
    logic                             ins_peak_q;
    logic [23:0]                      cnt_q;
    logic [7:0]                       tally_q;
    logic [monitor_pkg::SAMPLE_W-1:0] peak_q;
    logic [monitor_pkg::SAMPLE_W-1:0] peak_hold_q;
    logic                             expire;
    logic                             realign;
    logic                             sync_wr;

    assign wr_do   = aw_have_q && w_have_q && !bvalid;
    assign wr_idx  = awaddr_q[monitor_pkg::ADDR_W-1:2];
    assign rd_idx  = araddr[monitor_pkg::ADDR_W-1:2];
    assign sync_wr = wr_do && wlane_q && (wr_idx == monitor_pkg::IDX_SYNC_CTL);
    // a period of 0 or 1 simply expires every cycle
    assign expire  = (cnt_q <= 24'h000001);
    assign realign = sync_en_q && sysref_edge;

    // write address and data are taken independently and held until the write completes
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            awready   <= 1'b0;
            wready    <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 8'h00;
            wlane_q   <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= monitor_pkg::RESP_OKAY;
        end
        else
        begin
            if (!aw_have_q && !bvalid)
                awready <= !(awvalid && awready);
            if (!w_have_q && !bvalid)
                wready <= !(wvalid && wready);
            if (awvalid && awready)
            begin
                aw_have_q <= 1'b1;
                awaddr_q  <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_have_q <= 1'b1;
                wdata_q  <= wdata[7:0];
                wlane_q  <= wstrb[0];
            end
            if (wr_do)
            begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= (wr_idx >= monitor_pkg::IDX_SYNC_CTL &&
                              wr_idx <= monitor_pkg::IDX_INSERT_SEL) ?
                             monitor_pkg::RESP_OKAY : monitor_pkg::RESP_SLVERR;
            end
            else if (bvalid && bready)
            begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // read decode; reserved bits read as zero
    always_comb
    begin
        rd_hit  = 1'b1;
        rd_byte = 8'h00;
        unique case (rd_idx)
            monitor_pkg::IDX_SYNC_CTL:   rd_byte = {6'h00, sync_next_q, sync_en_q};
            monitor_pkg::IDX_CONTROL:    rd_byte = {6'h00, peak_en_q, 1'b0};
            monitor_pkg::IDX_PERIOD0:    rd_byte = period_q[7:0];
            monitor_pkg::IDX_PERIOD1:    rd_byte = period_q[15:8];
            monitor_pkg::IDX_PERIOD2:    rd_byte = period_q[23:16];
            monitor_pkg::IDX_READBACK:   rd_byte = {3'h0, update_q, 1'b0, sel_q};
            monitor_pkg::IDX_RESULT0:    rd_byte = result_q[7:0];
            monitor_pkg::IDX_RESULT1:    rd_byte = result_q[15:8];
            monitor_pkg::IDX_RESULT2:    rd_byte = {4'h0, result_q[19:16]};
            monitor_pkg::IDX_TALLY:      rd_byte = tally_rb_q;
            monitor_pkg::IDX_INSERT_EN:  rd_byte = {6'h00, insert_en_q};
            monitor_pkg::IDX_INSERT_SEL: rd_byte = {6'h00, ins_peak_q, 1'b0};
            default:                     rd_hit  = 1'b0;
        endcase
    end

    // one read at a time, answered the cycle after the address is taken
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= monitor_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h000000, rd_byte};
            rresp   <= rd_hit ? monitor_pkg::RESP_OKAY : monitor_pkg::RESP_SLVERR;
        end
        else if (rvalid && rready)
        begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
        else if (!rvalid)
            arready <= 1'b1;
    end

    // sync control: a software write in the clearing cycle wins, so a re-arm is not lost
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_en_q   <= 1'b0;
            sync_next_q <= 1'b0;
        end
        else if (sync_wr)
        begin
            sync_en_q   <= wdata_q[monitor_pkg::SYNC_EN_BIT];
            sync_next_q <= wdata_q[monitor_pkg::SYNC_NEXT_BIT];
        end
        else if (realign && sync_next_q)
            sync_en_q <= 1'b0;
    end

    // plain control registers; update bit is a one-cycle strobe
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            peak_en_q   <= 1'b0;
            period_q    <= monitor_pkg::PERIOD_RESET;
            sel_q       <= monitor_pkg::SEL_PEAK;
            update_q    <= 1'b0;
            insert_en_q <= 2'h0;
            ins_peak_q  <= monitor_pkg::INS_SEL_RESET;
        end
        else
        begin
            update_q <= 1'b0;
            if (wr_do && wlane_q)
            begin
                unique case (wr_idx)
                    monitor_pkg::IDX_CONTROL:    peak_en_q <= wdata_q[monitor_pkg::PEAK_EN_BIT];
                    monitor_pkg::IDX_PERIOD0:    period_q[7:0]   <= wdata_q;
                    monitor_pkg::IDX_PERIOD1:    period_q[15:8]  <= wdata_q;
                    monitor_pkg::IDX_PERIOD2:    period_q[23:16] <= wdata_q;
                    monitor_pkg::IDX_READBACK:
                    begin
                        sel_q    <= wdata_q[2:0];
                        update_q <= wdata_q[monitor_pkg::UPDATE_BIT];
                    end
                    monitor_pkg::IDX_INSERT_EN:  insert_en_q <= wdata_q[1:0];
                    monitor_pkg::IDX_INSERT_SEL: ins_peak_q  <= wdata_q[monitor_pkg::INS_PEAK_BIT];
                    default:                     ;
                endcase
            end
        end
    end

    // period counter; odd periods are not guarded against, software keeps them even
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            cnt_q <= monitor_pkg::PERIOD_RESET;
        else if (realign || expire)
            cnt_q <= period_q;
        else
            cnt_q <= cnt_q - 24'h000001;
    end

    // frame counter
    // an expiry that meets a realign still counts, so a matched sysref leaves
    // the measuring intervals and the count undisturbed
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            tally_q <= 8'h00;
        else if (expire)
            tally_q <= tally_q + 8'h01;
    end

    // peak tracking; an expiry always captures, a realign alone restarts
    // tracking without a capture, which drops the cut-short period
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            peak_q      <= '0;
            peak_hold_q <= '0;
        end
        else if (!peak_en_q)
        begin
            peak_q      <= '0;
            peak_hold_q <= '0;
        end
        else if (expire)
        begin
            peak_hold_q <= (sample_mag > peak_q) ? sample_mag : peak_q;
            peak_q      <= sample_mag;
        end
        else if (realign)
            peak_q <= sample_mag;
        else if (sample_mag > peak_q)
            peak_q <= sample_mag;
    end

    // readback latch, only the peak code yields result data; the tally is latched for any code
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            result_q   <= '0;
            tally_rb_q <= 8'h00;
        end
        else if (update_q)
        begin
            result_q   <= (sel_q == monitor_pkg::SEL_PEAK) ? {6'h00, peak_hold_q} : '0;
            tally_rb_q <= tally_q;
        end
    end

    // link frame insertion, one strobe per expired period
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            link_stat_valid <= 1'b0;
            link_stat_data  <= '0;
        end
        else
        begin
            link_stat_valid <= expire && peak_en_q &&
                               insert_en_q == monitor_pkg::INSERT_ON && ins_peak_q;
            if (expire)
                link_stat_data <= {6'h00, (sample_mag > peak_q) ? sample_mag : peak_q};
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    chk_sync_off_ignore: assert property (
        !sync_en_q && !expire && !sync_wr |=> cnt_q == $past(cnt_q) - 24'h000001)
        else $error("period counter moved while sync disabled");
    chk_sync_realign: assert property (
        realign && !expire && !wr_do |=> cnt_q == period_q && tally_q == $past(tally_q))
        else $error("sysref edge did not realign");
    chk_next_clear: assert property (
        realign && sync_next_q && !sync_wr |=> !sync_en_q && !realign)
        else $error("one-shot sync not cleared");
    chk_period_reload: assert property (
        expire && !wr_do |=> cnt_q == $past(period_q))
        else $error("period reload wrong");
    chk_update_latch: assert property (
        update_q |=> !update_q && tally_rb_q == $past(tally_q))
        else $error("readback latch wrong");
    chk_select_gate: assert property (
        update_q && sel_q != monitor_pkg::SEL_PEAK |=> result_q == '0)
        else $error("non-peak selection returned data");
    chk_frame_count: assert property (
        expire |=> tally_q == $past(tally_q) + 8'h01)
        else $error("frame counter missed an expiry");
    chk_link_insert: assert property (
        link_stat_valid |-> $past(expire) && $past(peak_en_q) && $past(ins_peak_q) &&
                            $past(insert_en_q) == monitor_pkg::INSERT_ON)
        else $error("link strobe without expiry");
    chk_peak_track: assert property (
        peak_en_q && !expire && !realign |=> peak_q >= $past(sample_mag))
        else $error("peak below a sample");
endmodule // signal_monitor

// [monitor_pkg.sv]
package monitor_pkg;
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_SYNC_CTL   = 10'h26f;
    localparam logic [9:0] IDX_CONTROL    = 10'h270;
    localparam logic [9:0] IDX_PERIOD0    = 10'h271;
    localparam logic [9:0] IDX_PERIOD1    = 10'h272;
    localparam logic [9:0] IDX_PERIOD2    = 10'h273;
    localparam logic [9:0] IDX_READBACK   = 10'h274;
    localparam logic [9:0] IDX_RESULT0    = 10'h275;
    localparam logic [9:0] IDX_RESULT1    = 10'h276;
    localparam logic [9:0] IDX_RESULT2    = 10'h277;
    localparam logic [9:0] IDX_TALLY      = 10'h278;
    localparam logic [9:0] IDX_INSERT_EN  = 10'h279;
    localparam logic [9:0] IDX_INSERT_SEL = 10'h27a;
    localparam int ADDR_W   = 12;
    localparam int SAMPLE_W = 14;
    localparam int RESULT_W = 20;
    // field positions
    localparam int SYNC_EN_BIT    = 0;
    localparam int SYNC_NEXT_BIT  = 1;
    localparam int PEAK_EN_BIT    = 1;
    localparam int UPDATE_BIT     = 4;
    localparam int INS_PEAK_BIT   = 1;
    // reset values and codes
    localparam logic [23:0] PERIOD_RESET  = 24'h000080;
    localparam logic [2:0]  SEL_PEAK      = 3'h1;
    localparam logic [1:0]  INSERT_ON     = 2'h3;
    localparam logic        INS_SEL_RESET = 1'h1;
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : monitor_pkg

// [signal_monitor_peak_stats_bench.sv]
module signal_monitor_peak_stats_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic                               sys_clk = 1'b0;
    logic                               resetn = 1'b0;
    logic [monitor_pkg::ADDR_W-1:0]     awaddr = 12'h0;
    logic [monitor_pkg::ADDR_W-1:0]     araddr = 12'h0;
    logic [31:0]                        wdata = 32'h0;
    logic [31:0]                        rdata;
    logic [31:0]                        rd;
    logic [3:0]                         wstrb = 4'hf;
    logic                               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic                               arvalid = 1'b0, rready = 1'b0;
    logic                               awready, wready, bvalid, arready, rvalid;
    logic [1:0]                         bresp, rresp, resp;
    logic [monitor_pkg::SAMPLE_W-1:0]   sample_mag = 14'h0;
    logic                               sysref_edge = 1'b0, sysref_run = 1'b0, peak_big = 1'b1;
    logic [monitor_pkg::RESULT_W-1:0]   link_stat_data;
    logic                               link_stat_valid;
    logic [7:0]                         delta;
    logic [3:0]                         link_phase = 4'h0;
    int                                 failures = 0, comparisons = 0, cyc = 0;
    int                                 link_pulses = 0, pulses;

    signal_monitor DUT (.sys_clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .sample_mag, .sysref_edge, .link_stat_data,
        .link_stat_valid);

    // 250 MHz system clock
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end

    // ramp repeats every 16 cycles, so any 16-cycle window holds its top value
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        sample_mag <= peak_big ? {cyc[3:0], 10'h0} : {4'h0, cyc[3:0], 6'h0};
        sysref_edge <= sysref_run && (cyc[4:0] == 5'h00);
        // remember the ramp phase at which each link strobe is seen
        if (link_stat_valid === 1'b1)
        begin
            link_pulses <= link_pulses + 1;
            link_phase  <= cyc[3:0];
        end
        if (cyc == 5000)
        begin
            failures = failures + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // each request stands until its ready is seen at a rising edge, then drops right after it;
    // one idle edge at the end keeps a following call from setting a signal twice in one step
    task automatic axi_wr(input logic [9:0] idx, input logic [7:0] d);
        awaddr <= {idx, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (awvalid && awready === 1'b1)
                awvalid <= 1'b0;
            if (wvalid && wready === 1'b1)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic axi_rd(input logic [9:0] idx);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (arvalid && arready === 1'b1)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
        axi_rd(idx);
        check(rd, {24'h0, exp});
        check({30'h0, resp}, {30'h0, monitor_pkg::RESP_OKAY});
    endtask

    // two result updates exactly 160 cycles apart: tally and link pulses in between
    task automatic window(output logic [7:0] d, output int p);
        time        t0;
        logic [7:0] first;
        int         p0;
        t0 = $time;
        p0 = link_pulses;
        axi_wr(monitor_pkg::IDX_READBACK, 8'h11);
        axi_rd(monitor_pkg::IDX_TALLY);
        first = rd[7:0];
        while ($time - t0 < 640)
            @(posedge sys_clk);
        p = link_pulses - p0;
        axi_wr(monitor_pkg::IDX_READBACK, 8'h11);
        axi_rd(monitor_pkg::IDX_TALLY);
        d = rd[7:0] - first;
    endtask

    initial
    begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rd_chk(monitor_pkg::IDX_SYNC_CTL, 8'h00);
        rd_chk(monitor_pkg::IDX_CONTROL, 8'h00);
        rd_chk(monitor_pkg::IDX_PERIOD0, 8'h80);
        rd_chk(monitor_pkg::IDX_PERIOD1, 8'h00);
        rd_chk(monitor_pkg::IDX_PERIOD2, 8'h00);
        rd_chk(monitor_pkg::IDX_READBACK, 8'h01);
        rd_chk(monitor_pkg::IDX_RESULT2, 8'h00);
        rd_chk(monitor_pkg::IDX_TALLY, 8'h00);
        rd_chk(monitor_pkg::IDX_INSERT_EN, 8'h00);
        rd_chk(monitor_pkg::IDX_INSERT_SEL, 8'h02);
        axi_rd(10'h27b);
        check(rd, 32'h0);
        check({30'h0, resp}, {30'h0, monitor_pkg::RESP_SLVERR});
        // a write without lane 0 is ignored
        wstrb <= 4'he;
        axi_wr(monitor_pkg::IDX_PERIOD1, 8'h55);
        wstrb <= 4'hf;
        check({30'h0, resp}, {30'h0, monitor_pkg::RESP_OKAY});
        rd_chk(monitor_pkg::IDX_PERIOD1, 8'h00);
        $display("test reset_values done");
        // the old 128-cycle period must run out before the new one counts
        axi_wr(monitor_pkg::IDX_PERIOD0, 8'h10);
        axi_wr(monitor_pkg::IDX_CONTROL, 8'h02);
        axi_wr(monitor_pkg::IDX_INSERT_EN, 8'h03);
        repeat (140) @(posedge sys_clk);
        window(delta, pulses);
        check({24'h0, delta}, 32'ha);
        check(32'(pulses), 32'ha);
        rd_chk(monitor_pkg::IDX_READBACK, 8'h01);
        rd_chk(monitor_pkg::IDX_RESULT0, 8'h00);
        rd_chk(monitor_pkg::IDX_RESULT1, 8'h3c);
        check({12'h0, link_stat_data}, 32'h3c00);
        peak_big <= 1'b0;
        repeat (40) @(posedge sys_clk);
        axi_wr(monitor_pkg::IDX_READBACK, 8'h11);
        rd_chk(monitor_pkg::IDX_RESULT0, 8'hc0);
        rd_chk(monitor_pkg::IDX_RESULT1, 8'h03);
        check({12'h0, link_stat_data}, 32'h3c0);
        axi_wr(monitor_pkg::IDX_READBACK, 8'h12);
        rd_chk(monitor_pkg::IDX_RESULT1, 8'h00);
        $display("test peak_period done");
        axi_wr(monitor_pkg::IDX_INSERT_SEL, 8'h00);
        window(delta, pulses);
        check(32'(pulses), 32'h0);
        axi_wr(monitor_pkg::IDX_INSERT_EN, 8'h00);
        axi_wr(monitor_pkg::IDX_INSERT_SEL, 8'h02);
        window(delta, pulses);
        check(32'(pulses), 32'h0);
        $display("test link_insert done");
        // sysref every 32 cycles: once aligned, link strobes land two cycles into the ramp
        axi_wr(monitor_pkg::IDX_INSERT_EN, 8'h03);
        sysref_run <= 1'b1;
        window(delta, pulses);
        check({24'h0, delta}, 32'ha);
        axi_wr(monitor_pkg::IDX_SYNC_CTL, 8'h01);
        repeat (40) @(posedge sys_clk);
        window(delta, pulses);
        check({24'h0, delta}, 32'ha);
        check({28'h0, link_phase}, 32'h2);
        rd_chk(monitor_pkg::IDX_SYNC_CTL, 8'h01);
        axi_wr(monitor_pkg::IDX_SYNC_CTL, 8'h03);
        repeat (40) @(posedge sys_clk);
        window(delta, pulses);
        check({24'h0, delta}, 32'ha);
        check({28'h0, link_phase}, 32'h2);
        rd_chk(monitor_pkg::IDX_SYNC_CTL, 8'h02);
        $display("test sysref_sync done");
        end_sim();
    end
endmodule // signal_monitor_peak_stats_bench
